/* File: rtl/wdsc_defines.svh */
// constants of the watchdog and sleep control block
// assumes inclusion by bare name from the top module
`ifndef WDSC_DEFINES_SVH
`define WDSC_DEFINES_SVH
`define WDSC_OPT_IDX 16'h0081
`define WDSC_CFG_IDX 16'h2007
`define WDSC_ID_IDX 16'h2000
`define WDSC_CTL_ADDR 18'h00000
`define WDSC_OPT_RST 8'hFF
`define WDSC_CFG_RST 8'hFF
`define WDSC_OPT_PSA 3
`define WDSC_OPT_PS 2:0
`define WDSC_CFG_WATCHDOG_ENABLE_FUSE 2
`define WDSC_CFG_CP0 4
`define WDSC_CFG_FOSC 1:0
`define WDSC_FOSC_RC 2'h3
`define WDSC_ST_TO 4
`define WDSC_ST_PD 3
`define WDSC_ST_ASLEEP 0
`define WDSC_CMD_CLR 0
`define WDSC_CMD_SLEEP 1
`define WDSC_WAKE_MASK 8'hF7
`define WDSC_OST_TOSC 1024
`define WDSC_TOSC_NS 20
`define WDSC_CLK_NS 20
`define WDSC_OST_CYC ((`WDSC_OST_TOSC * `WDSC_TOSC_NS + `WDSC_CLK_NS - 1) / `WDSC_CLK_NS)
`define WDSC_WDT_BASE 16'h0012
`endif

/* File: rtl/wdsc_pkg.sv */
// types of the watchdog and sleep control block
// assumes wdsc_defines.svh is on the include path
package wdsc_pkg;
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_OST} wdsc_fsm_t;
    typedef enum logic [2:0] {SEL_NONE, SEL_CTL, SEL_OPT, SEL_CFG, SEL_ID} wdsc_sel_t;
    typedef struct packed {
        wdsc_sel_t sel;
        logic [1:0] idx;
    } wdsc_dec_t;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } wdsc_io_t;
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] enables;
        logic global_irq_enable;
    } wdsc_irq_t;
    typedef struct packed {
        wdsc_fsm_t fsm;
        logic [15:0] wdt_cnt;
        logic [7:0] pre_cnt;
        logic [7:0] option;
        logic [7:0] config_w;
        logic [3:0][7:0] idw;
        logic to_flag;
        logic pd_flag;
        logic wdt_cause;
        logic wake_irq;
        logic [10:0] ost_cnt;
        logic [12:0] resume_pc;
        wdsc_io_t io;
        logic dev_rst;
        logic wake;
        logic vector;
        logic tmr0_inc;
        logic a_wr;
        wdsc_dec_t a_dec;
        logic [31:0] rdata;
    } wdsc_state_t;
endpackage : wdsc_pkg

/* File: rtl/wdsc_top.sv */
// watchdog timer with shared prescaler, sleep entry and wake-up control
// assumes a core that raises commands over AHB-Lite and synchronous inputs
// How it works
// - watchdog counts ticks of its own RC oscillator, also during sleep
// - expiry while running gives a device reset marked as watchdog
// - expiry while asleep wakes the core instead of resetting
// - any expiry clears the expiry flag
// - watchdog enable fuse low stops the watchdog for good
// - one prescaler, assign bit picks timer or watchdog, three ratio bits
// - clear and sleep commands zero counter and assigned postscaler
// - clear zeroes prescaler count only when assigned to watchdog, keeps its assignment
// - sleep clears watchdog, clears sleep flag, sets expiry flag, stops osc
// - pin drive states are frozen through sleep
// - reset pin resets state, option and counters but keeps the status flags; expiry or interrupt wake and continue
// - sleep flag set at power-up, cleared only by a real sleep
// - only clockless interrupt sources can wake from sleep
// - next program address is latched at sleep for first execution
// - wake needs the source enable only, global enable ignored
// - after wake, vector only if global enable set, else in line
// - pending enabled interrupt with global off turns sleep into no-op
// - interrupt during sleep execution: finish sleep, then wake at once
// - crystal modes wait 1024 oscillator periods after wake, RC none
// - four ID words reachable only in program/verify mode
// - program memory read-out allowed while code protect unprogrammed
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "wdsc_defines.svh"

module wdsc_top #(
    parameter logic [15:0] WDT_BASE_TICKS = `WDSC_WDT_BASE
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    // watchdog oscillator and timer side
    input wire logic WDT_OSC_TICK,
    input wire logic TMR0_TICK,
    output logic TMR0_INC,
    // core, pins and interrupts
    input wire logic EXT_RESET_PIN_N,
    input wire logic PROG_MODE,
    input wire logic [12:0] CORE_PC,
    input wire wdsc_pkg::wdsc_irq_t IRQ,
    input wire wdsc_pkg::wdsc_io_t IO_IN,
    output wdsc_pkg::wdsc_io_t IO_OUT,
    // power and reset control
    output logic DEVICE_RESET,
    output logic WDT_RESET_CAUSE,
    output logic OSC_DRIVER_EN,
    output logic CORE_RUN,
    output logic WAKE_PULSE,
    output logic WAKE_VECTOR,
    output logic [12:0] RESUME_PC,
    output logic [7:0] STATUS_FLAGS,
    output logic VERIFY_READ_EN
);

    wdsc_pkg::wdsc_state_t s;
    wdsc_pkg::wdsc_state_t n;

    // byte address of a printed register index
    function automatic logic [17:0] idx_addr(input logic [15:0] idx);
        idx_addr = {idx, 2'h0};
    endfunction : idx_addr

    function automatic wdsc_pkg::wdsc_dec_t decode(input logic [31:0] a);
        decode.sel = wdsc_pkg::SEL_NONE;
        decode.idx = a[3:2];
        if (a[31:18] != 14'h0000) begin
            decode.sel = wdsc_pkg::SEL_NONE;
        end else if (a[17:0] == `WDSC_CTL_ADDR) begin
            decode.sel = wdsc_pkg::SEL_CTL;
        end else if (a[17:0] == idx_addr(`WDSC_OPT_IDX)) begin
            decode.sel = wdsc_pkg::SEL_OPT;
        end else if (a[17:0] == idx_addr(`WDSC_CFG_IDX)) begin
            decode.sel = wdsc_pkg::SEL_CFG;
        end else if (a[17:4] == idx_addr(`WDSC_ID_IDX) >> 4) begin
            decode.sel = wdsc_pkg::SEL_ID;
        end
    endfunction : decode

    // last count of the shared scaler: watchdog 1:2^ps, timer 1:2^(ps+1)
    function automatic logic [7:0] ratio_last(input logic [2:0] ps, input logic to_wdt);
        logic [8:0] full;
        full = 9'h001 << ps;
        if (!to_wdt) begin
            full = full << 1;
        end
        ratio_last = full[7:0] - 8'h01;
    endfunction : ratio_last

    logic acc;
    logic clr_cmd;
    logic slp_cmd;
    logic wdt_on;
    logic prescaler_assign_select;
    logic base_exp;
    logic expire;
    logic pend;
    logic wake_src;
    logic crystal;
    logic [31:0] rd_val;

    always_comb begin
        n = s;
        n.dev_rst = 1'b0;
        n.wake = 1'b0;
        n.vector = 1'b0;
        n.tmr0_inc = 1'b0;
        clr_cmd = 1'b0;
        slp_cmd = 1'b0;
        base_exp = 1'b0;
        expire = 1'b0;
        rd_val = 32'h00000000;
        wdt_on = s.config_w[`WDSC_CFG_WATCHDOG_ENABLE_FUSE];
        prescaler_assign_select = s.option[`WDSC_OPT_PSA];
        crystal = s.config_w[`WDSC_CFG_FOSC] != `WDSC_FOSC_RC;
        pend = |(IRQ.flags & IRQ.enables);
        wake_src = |(IRQ.flags & IRQ.enables & `WDSC_WAKE_MASK);

        // address phase: decode and prepare read data
        acc = HSEL & HTRANS[1] & HREADY;
        n.a_wr = acc & HWRITE;
        n.a_dec = decode(HADDR);
        case (n.a_dec.sel)
            wdsc_pkg::SEL_CTL: begin
                rd_val[`WDSC_ST_TO] = s.to_flag;
                rd_val[`WDSC_ST_PD] = s.pd_flag;
                rd_val[`WDSC_ST_ASLEEP] = s.fsm != wdsc_pkg::ST_RUN;
            end
            wdsc_pkg::SEL_OPT: begin
                rd_val[7:0] = s.option;
            end
            wdsc_pkg::SEL_CFG: begin
                rd_val[7:0] = s.config_w;
            end
            wdsc_pkg::SEL_ID: begin
                if (PROG_MODE) begin
                    rd_val[7:0] = s.idw[n.a_dec.idx];
                end
            end
            default: begin
                rd_val = 32'h00000000;
            end
        endcase
        if (acc && !HWRITE) begin
            n.rdata = rd_val;
        end

        // data phase: apply write
        if (s.a_wr) begin
            case (s.a_dec.sel)
                wdsc_pkg::SEL_CTL: begin
                    clr_cmd = HWDATA[`WDSC_CMD_CLR];
                    slp_cmd = HWDATA[`WDSC_CMD_SLEEP];
                end
                wdsc_pkg::SEL_OPT: begin
                    n.option = HWDATA[7:0];
                end
                wdsc_pkg::SEL_CFG: begin
                    if (PROG_MODE) begin
                        n.config_w = HWDATA[7:0];
                    end
                end
                wdsc_pkg::SEL_ID: begin
                    if (PROG_MODE) begin
                        n.idw[s.a_dec.idx] = HWDATA[7:0];
                    end
                end
                default: begin
                    clr_cmd = 1'b0;
                end
            endcase
        end

        // base counter on the rc oscillator tick
        if (WDT_OSC_TICK && wdt_on) begin
            if (s.wdt_cnt >= WDT_BASE_TICKS - 16'h0001) begin
                n.wdt_cnt = 16'h0000;
                base_exp = 1'b1;
            end else begin
                n.wdt_cnt = s.wdt_cnt + 16'h0001;
            end
        end

        // shared scaler: postscaler for watchdog, prescaler for timer
        if (prescaler_assign_select) begin
            if (base_exp) begin
                if (s.pre_cnt >= ratio_last(s.option[`WDSC_OPT_PS], 1'b1)) begin
                    n.pre_cnt = 8'h00;
                    expire = 1'b1;
                end else begin
                    n.pre_cnt = s.pre_cnt + 8'h01;
                end
            end
        end else begin
            expire = base_exp;
            if (TMR0_TICK) begin
                if (s.pre_cnt >= ratio_last(s.option[`WDSC_OPT_PS], 1'b0)) begin
                    n.pre_cnt = 8'h00;
                    n.tmr0_inc = 1'b1;
                end else begin
                    n.pre_cnt = s.pre_cnt + 8'h01;
                end
            end
        end

        // clear command
        if (clr_cmd && s.fsm == wdsc_pkg::ST_RUN) begin
            n.wdt_cnt = 16'h0000;
            expire = 1'b0;
            if (prescaler_assign_select) begin
                n.pre_cnt = 8'h00;
            end
            n.to_flag = 1'b1;
            n.pd_flag = 1'b1;
        end

        // sleep command; pending source with global off makes it a no-op
        if (slp_cmd && s.fsm == wdsc_pkg::ST_RUN && !(pend && !IRQ.global_irq_enable)) begin
            n.wdt_cnt = 16'h0000;
            expire = 1'b0;
            if (prescaler_assign_select) begin
                n.pre_cnt = 8'h00;
            end
            n.pd_flag = 1'b0;
            n.to_flag = 1'b1;
            n.io = IO_IN;
            n.resume_pc = CORE_PC + 13'h0001;
            n.fsm = wdsc_pkg::ST_SLEEP;
        end

        // pins follow the core while running, frozen otherwise
        if (s.fsm == wdsc_pkg::ST_RUN && n.fsm == wdsc_pkg::ST_RUN) begin
            n.io = IO_IN;
        end

        case (s.fsm)
            wdsc_pkg::ST_RUN: begin
                if (expire) begin
                    n.dev_rst = 1'b1;
                    n.wdt_cause = 1'b1;
                    n.to_flag = 1'b0;
                    n.pd_flag = 1'b1;
                    n.option = `WDSC_OPT_RST;
                    n.wdt_cnt = 16'h0000;
                    n.pre_cnt = 8'h00;
                    n.fsm = wdsc_pkg::ST_RUN;
                end
            end
            wdsc_pkg::ST_SLEEP: begin
                if (expire || wake_src) begin
                    if (expire) begin
                        n.to_flag = 1'b0;
                    end
                    n.wake_irq = wake_src && !expire;
                    if (crystal) begin
                        n.ost_cnt = 11'(`WDSC_OST_CYC - 1);
                        n.fsm = wdsc_pkg::ST_OST;
                    end else begin
                        n.wake = 1'b1;
                        n.vector = wake_src && !expire && IRQ.global_irq_enable;
                        n.fsm = wdsc_pkg::ST_RUN;
                    end
                end
            end
            wdsc_pkg::ST_OST: begin
                if (s.ost_cnt == 11'h000) begin
                    n.wake = 1'b1;
                    n.vector = s.wake_irq && IRQ.global_irq_enable;
                    n.fsm = wdsc_pkg::ST_RUN;
                end else begin
                    n.ost_cnt = s.ost_cnt - 11'h001;
                end
                if (expire) begin
                    n.to_flag = 1'b0;
                end
            end
            default: begin
                n.fsm = wdsc_pkg::ST_RUN;
            end
        endcase

        // reset pin overrides state, option, counters, cause and wake outputs; flags kept for cause checking
        if (!EXT_RESET_PIN_N) begin
            n.dev_rst = 1'b1;
            n.wdt_cause = 1'b0;
            n.wake = 1'b0;
            n.vector = 1'b0;
            n.option = `WDSC_OPT_RST;
            n.wdt_cnt = 16'h0000;
            n.pre_cnt = 8'h00;
            n.fsm = wdsc_pkg::ST_RUN;
        end
    end

    // power-up values: expiry and sleep flags both set
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s <= '0;
            s.fsm <= wdsc_pkg::ST_RUN;
            s.option <= `WDSC_OPT_RST;
            s.config_w <= `WDSC_CFG_RST;
            s.to_flag <= 1'b1;
            s.pd_flag <= 1'b1;
            s.io.oe_n <= 8'hFF;
        end else begin
            s <= n;
        end
    end

    // zero wait state, always okay
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = s.rdata;
    assign TMR0_INC = s.tmr0_inc;
    assign IO_OUT = s.io;
    assign DEVICE_RESET = s.dev_rst;
    assign WDT_RESET_CAUSE = s.wdt_cause;
    assign OSC_DRIVER_EN = s.fsm == wdsc_pkg::ST_RUN || s.fsm == wdsc_pkg::ST_OST;
    assign CORE_RUN = s.fsm == wdsc_pkg::ST_RUN;
    assign WAKE_PULSE = s.wake;
    assign WAKE_VECTOR = s.vector;
    assign RESUME_PC = s.resume_pc;
    assign STATUS_FLAGS = {3'h0, s.to_flag, s.pd_flag, 3'h0};
    // unprogrammed protect bit reads as one
    assign VERIFY_READ_EN = s.config_w[`WDSC_CFG_CP0];

endmodule : wdsc_top

`default_nettype wire

/* File: tb/wdsc_properties.sv */
// concurrent checks for the watchdog and sleep control top
// assumes binding onto wdsc_top, one clock, synchronous reset
`timescale 1ns/10ps
`default_nettype none
module wdsc_chk (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // core side
    input wire logic EXT_RESET_PIN_N,
    input wire logic [12:0] CORE_PC,
    input wire wdsc_pkg::wdsc_irq_t IRQ,
    input wire wdsc_pkg::wdsc_io_t IO_OUT,
    // power control
    input wire logic DEVICE_RESET,
    input wire logic OSC_DRIVER_EN,
    input wire logic CORE_RUN,
    input wire logic WAKE_PULSE,
    input wire logic WAKE_VECTOR,
    input wire logic [12:0] RESUME_PC,
    input wire logic [7:0] STATUS_FLAGS
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    osc_off_a: assert property (!OSC_DRIVER_EN |-> !CORE_RUN)
        else $error("oscillator off while running");
    pins_frozen_a: assert property (!CORE_RUN && !$past(CORE_RUN) |-> $stable(IO_OUT))
        else $error("pins moved in sleep");
    wake_run_a: assert property (WAKE_PULSE |-> CORE_RUN && !$past(CORE_RUN))
        else $error("wake pulse without resume");
    vector_wake_a: assert property (WAKE_VECTOR |-> WAKE_PULSE)
        else $error("vector outside wake");
    pd_clear_a: assert property ($fell(STATUS_FLAGS[3]) |-> $fell(CORE_RUN))
        else $error("sleep flag cleared without sleep");
    sleep_entry_a: assert property ($fell(CORE_RUN) |-> STATUS_FLAGS[4] && !OSC_DRIVER_EN
        && RESUME_PC == 13'($past(CORE_PC) + 13'h1))
        else $error("sleep entry state wrong");
    wdt_reset_a: assert property (DEVICE_RESET && $past(EXT_RESET_PIN_N) |-> !STATUS_FLAGS[4])
        else $error("watchdog reset without expiry flag");
    irq_wake_a: assert property (!OSC_DRIVER_EN && |(IRQ.flags & IRQ.enables & 8'hF7)
        |=> OSC_DRIVER_EN)
        else $error("enabled source did not wake");
    wdt_wake_a: assert property ($fell(STATUS_FLAGS[4]) && !$past(CORE_RUN) |-> ##[0:2] OSC_DRIVER_EN)
        else $error("expiry in sleep did not wake");
    wake_vec_c: cover property (WAKE_VECTOR);
    wdt_rst_c: cover property (DEVICE_RESET && EXT_RESET_PIN_N);
    startup_c: cover property (!CORE_RUN && OSC_DRIVER_EN);
endmodule : wdsc_chk
bind wdsc_top wdsc_chk u_chk (.REF_CLK, .RST, .EXT_RESET_PIN_N, .CORE_PC, .IRQ, .IO_OUT,
    .DEVICE_RESET, .OSC_DRIVER_EN, .CORE_RUN, .WAKE_PULSE, .WAKE_VECTOR, .RESUME_PC, .STATUS_FLAGS);
`default_nettype wire

/* File: tb/wdsc_tb.sv */
// self-checking bench for the watchdog and sleep control top
// assumes the bench is the only bus master and drives every pin
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int BASE = 4;
    localparam logic [31:0] CTL = 32'h00000000;
    localparam logic [31:0] OPT = 32'h00000204;
    localparam logic [31:0] CFG = 32'h0000801C;
    localparam logic [31:0] ID3 = 32'h0000800C;
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic HSEL = 1'b1;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0;
    logic HREADY = 1'b1;
    logic WDT_OSC_TICK = 1'b0;
    logic TMR0_TICK = 1'b0;
    logic EXT_RESET_PIN_N = 1'b1;
    logic PROG_MODE = 1'b0;
    logic [12:0] CORE_PC = 13'h0123;
    wdsc_pkg::wdsc_irq_t IRQ = '0;
    wdsc_pkg::wdsc_io_t IO_IN = '0;
    wdsc_pkg::wdsc_io_t IO_OUT;
    logic HREADYOUT, HRESP, TMR0_INC, DEVICE_RESET, WDT_RESET_CAUSE, OSC_DRIVER_EN;
    logic CORE_RUN, WAKE_PULSE, WAKE_VECTOR, VERIFY_READ_EN;
    logic [31:0] HRDATA;
    logic [12:0] RESUME_PC;
    logic [7:0] STATUS_FLAGS;
    logic [31:0] rd;
    int mismatches = 0;
    int checks_done = 0;
    int n_rst = 0;
    int n_wake = 0;
    int n_inc = 0;
    int r0, w0, n, n_rc;
    always #10 REF_CLK = ~REF_CLK;
    // pulses are one cycle wide, so count them here rather than poll
    always @(posedge REF_CLK) begin
        if (DEVICE_RESET === 1'b1) n_rst++;
        if (WAKE_PULSE === 1'b1) n_wake++;
        if (TMR0_INC === 1'b1) n_inc++;
    end
    wdsc_top #(.WDT_BASE_TICKS(16'(BASE))) dut (.REF_CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
        .HWDATA, .HREADY, .HREADYOUT, .HRESP, .HRDATA, .WDT_OSC_TICK, .TMR0_TICK, .TMR0_INC,
        .EXT_RESET_PIN_N, .PROG_MODE, .CORE_PC, .IRQ, .IO_IN, .IO_OUT, .DEVICE_RESET, .WDT_RESET_CAUSE,
        .OSC_DRIVER_EN, .CORE_RUN, .WAKE_PULSE, .WAKE_VECTOR, .RESUME_PC, .STATUS_FLAGS, .VERIFY_READ_EN);
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge REF_CLK);
    endtask : cyc
    // bounded wait for hready sampled high
    task automatic rdy();
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge REF_CLK);
            if (HREADYOUT === 1'b1) break;
        end
        if (i == 50) begin
            mismatches++;
            final_report();
        end
    endtask : rdy
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= wr;
        rdy();
        HTRANS <= 2'h0;
        HWDATA <= d;
        rdy();
        rd = HRDATA;
    endtask : ahb
    task automatic tick(input int k);
        repeat (k) begin
            WDT_OSC_TICK <= 1'b1;
            cyc(1);
            WDT_OSC_TICK <= 1'b0;
            cyc(3);
        end
    endtask : tick
    task automatic t_regs();
        ahb(1'b0, CTL, 0); chk(rd, 32'h18);
        ahb(1'b0, OPT, 0); chk(rd, 32'hFF);
        ahb(1'b0, 32'h100, 0); chk(rd, 32'h0);
    endtask : t_regs
    task automatic t_id();
        PROG_MODE <= 1'b1;
        ahb(1'b1, ID3, 32'h0A);
        ahb(1'b0, ID3, 0); chk(rd, 32'h0A);
        PROG_MODE <= 1'b0;
        ahb(1'b1, ID3, 32'h03);
        ahb(1'b0, ID3, 0); chk(rd, 32'h0);
        PROG_MODE <= 1'b1;
        ahb(1'b1, CFG, 32'hEF);
        ahb(1'b0, ID3, 0); chk(rd, 32'h0A);
        chk(VERIFY_READ_EN, 0);
        ahb(1'b1, CFG, 32'hFF);
        cyc(1); chk(VERIFY_READ_EN, 1);
        PROG_MODE <= 1'b0;
    endtask : t_id
    task automatic t_wdt_reset();
        ahb(1'b1, OPT, 32'h08);
        r0 = n_rst;
        tick(BASE - 1); chk(n_rst - r0, 0);
        tick(1); chk(n_rst - r0, 1);
        chk(STATUS_FLAGS, 8'h08);
        chk(WDT_RESET_CAUSE, 1);
        ahb(1'b0, OPT, 0); chk(rd, 32'hFF);
        EXT_RESET_PIN_N <= 1'b0;
        cyc(3);
        EXT_RESET_PIN_N <= 1'b1;
        cyc(2); chk(WDT_RESET_CAUSE, 0);
    endtask : t_wdt_reset
    task automatic t_clear();
        ahb(1'b1, OPT, 32'h08);
        r0 = n_rst;
        tick(BASE - 1);
        ahb(1'b1, CTL, 1);
        tick(BASE - 1); chk(n_rst - r0, 0);
        ahb(1'b0, OPT, 0); chk(rd, 32'h08);
        chk(STATUS_FLAGS, 8'h18);
    endtask : t_clear
    // scaler on the timer, ratio 1:2
    task automatic t_timer();
        ahb(1'b1, OPT, 32'h00);
        r0 = n_inc;
        repeat (4) begin
            TMR0_TICK <= 1'b1;
            cyc(1);
            TMR0_TICK <= 1'b0;
            cyc(1);
        end
        cyc(2); chk(n_inc - r0, 2);
        chk(HRESP, 0);
        ahb(1'b1, OPT, 32'h08);
    endtask : t_timer
    // sleep, try a clocked-only source, then wake; cnt = edges to wake
    task automatic sleep_wake(input logic g, output int cnt);
        IRQ <= {8'h00, 8'h09, g};
        IO_IN <= 16'hA50F;
        ahb(1'b1, CTL, 2);
        cyc(2); chk(CORE_RUN, 0);
        chk(STATUS_FLAGS, 8'h10);
        chk(OSC_DRIVER_EN, 0);
        chk(RESUME_PC, 13'h0124);
        IO_IN <= 16'h5AF0;
        IRQ.flags <= 8'h08;
        cyc(3); chk(IO_OUT, 16'hA50F);
        chk(CORE_RUN, 0);
        IRQ.flags <= 8'h01;
        for (cnt = 0; cnt < 2000 && WAKE_PULSE !== 1'b1; cnt++) cyc(1);
        chk(WAKE_VECTOR, g);
        if (cnt == 2000) final_report();
        IRQ <= '0;
        cyc(2);
    endtask : sleep_wake
    task automatic t_noop();
        ahb(1'b1, CTL, 1);
        IRQ <= {8'h01, 8'h01, 1'b0};
        ahb(1'b1, CTL, 2);
        cyc(3); chk(CORE_RUN, 1);
        chk(STATUS_FLAGS, 8'h18);
        IRQ <= '0;
    endtask : t_noop
    task automatic t_wdt_wake();
        r0 = n_rst;
        w0 = n_wake;
        ahb(1'b1, CTL, 2);
        cyc(2);
        tick(BASE + 1); chk(n_rst - r0, 0);
        chk(n_wake - w0, 1);
        chk(STATUS_FLAGS[4], 0);
        ahb(1'b1, CTL, 1);
    endtask : t_wdt_wake
    initial begin
        repeat (12) @(posedge REF_CLK);
        RST <= 1'b0;
        t_regs();
        t_id();
        t_wdt_reset();
        t_clear();
        t_timer();
        sleep_wake(1'b0, n_rc);
        sleep_wake(1'b1, n); chk(n, n_rc);
        t_noop();
        t_wdt_wake();
        PROG_MODE <= 1'b1;
        ahb(1'b1, CFG, 32'hFC);
        sleep_wake(1'b0, n); chk(n, n_rc + 1024);
        final_report();
    end
endmodule : testbench
`default_nettype wire
